// file: verilog/aodec_pkg.sv
/*
  Package for the accumulator/memory-reference instruction decoder:
  opcode patterns, field positions and operation selects.
  Assumes 16-bit instruction words from the program fetch path.
*/
package aodec_pkg;

  // ----------------------------------------------------------------
  // Word layout
  // ----------------------------------------------------------------
  localparam int AODEC_WORD_W     = 16;      // Instruction width
  localparam int AODEC_NIB_HI     = 15;      // Top nibble msb
  localparam int AODEC_NIB_LO     = 12;      // Top nibble lsb
  localparam int AODEC_BYTE_HI    = 15;      // Upper byte msb
  localparam int AODEC_BYTE_LO    = 8;       // Upper byte lsb
  localparam int AODEC_SHIFT4_HI  = 11;      // Four-bit shift code msb
  localparam int AODEC_SHIFT4_LO  = 8;       // Four-bit shift code lsb
  localparam int AODEC_SHIFT3_HI  = 10;      // Three-bit shift msb
  localparam int AODEC_SHIFT3_LO  = 8;       // Three-bit shift lsb
  localparam int AODEC_MODE_BIT   = 7;       // Addressing-mode bit
  localparam int AODEC_DMA_HI     = 6;       // Direct address msb
  localparam int AODEC_DMA_LO     = 0;       // Direct address lsb
  localparam int AODEC_CONST_HI   = 7;       // Short constant msb
  localparam int AODEC_CONST_LO   = 0;       // Short constant lsb
  localparam int AODEC_INC_BIT    = 5;       // Post-increment control
  localparam int AODEC_DEC_BIT    = 4;       // Post-decrement control
  localparam int AODEC_KEEP_BIT   = 3;       // Pointer keep control
  localparam int AODEC_PTR_BIT    = 0;       // New pointer value
  localparam int AODEC_SH3_TOP    = 11;      // Fixed one of 0101 1xxx

  // ----------------------------------------------------------------
  // Opcode patterns
  // ----------------------------------------------------------------
  localparam logic [3:0]  AODEC_NIB_ADD   = 4'h0;        // 0000 SSSS
  localparam logic [3:0]  AODEC_NIB_LOAD  = 4'h2;        // 0010 SSSS
  localparam logic [3:0]  AODEC_NIB_STH   = 4'h5;        // 0101 1xxx
  localparam logic [7:0]  AODEC_OP_ADD_UPPER_HALF_OP   = 8'h60;
  localparam logic [7:0]  AODEC_OP_ADD_UNSIGNED_LOWER_OP   = 8'h61;
  localparam logic [7:0]  AODEC_OP_SUB_UPPER_HALF_OP   = 8'h62;
  localparam logic [7:0]  AODEC_OP_LDK    = 8'h7e;
  localparam logic [15:0] AODEC_WORD_MAG  = 16'h7f88;    // Fixed magnitude word

  // ----------------------------------------------------------------
  // Operation selects and instruction classes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    AODEC_SEL_NONE,
    AODEC_SEL_MAGNITUDE,
    AODEC_SEL_ADD_SHIFTED,
    AODEC_SEL_ADD_UPPER,
    AODEC_SEL_ADD_UNSIGNED,
    AODEC_SEL_LOAD_SHIFTED,
    AODEC_SEL_LOAD_CONST,
    AODEC_SEL_STORE_UPPER,
    AODEC_SEL_SUB_UPPER
  } aodec_sel_t;

  typedef enum logic [1:0] {
    AODEC_CLASS_ACC_MEM,     // This group
    AODEC_CLASS_BRANCH,      // Branch group
    AODEC_CLASS_IO,          // Input/output group
    AODEC_CLASS_OTHER        // Any other group
  } aodec_class_t;

endpackage

// file: verilog/aodec_fields.sv
/*
  Field extractor for the accumulator/memory-reference decoder.
  Purely combinational; assumes a 16-bit word and a page pointer bit.
*/
`timescale 1ns/10ps
module aodec_fields
  import aodec_pkg::*;
(
  input  wire logic [15:0] word,               // Instruction word
  input  wire logic        page_select_bit,    // Data page pointer
  output logic      [3:0]  shift4,             // Four-bit shift code
  output logic      [2:0]  shift3,             // Store shift field
  output logic             indirect,           // Addressing-mode bit
  output logic      [6:0]  dma,                // Seven-bit address
  output logic      [7:0]  direct_addr,        // Page-joined address
  output logic      [7:0]  short_const,        // Immediate constant
  output logic             post_inc,           // Indirect increment
  output logic             post_dec,           // Indirect decrement
  output logic             ptr_load,           // Load new pointer
  output logic             ptr_value           // New pointer value
);

  // ----------------------------------------------------------------
  // Field slicing
  // ----------------------------------------------------------------
  always_comb begin
    shift4      = word[AODEC_SHIFT4_HI:AODEC_SHIFT4_LO];           // RQ11
    shift3      = word[AODEC_SHIFT3_HI:AODEC_SHIFT3_LO];           // RQ12
    indirect    = word[AODEC_MODE_BIT];                            // RQ13
    dma         = word[AODEC_DMA_HI:AODEC_DMA_LO];                 // RQ13
    direct_addr = {page_select_bit, dma};                          // RQ15
    short_const = word[AODEC_CONST_HI:AODEC_CONST_LO];
    // Indirect controls only mean something with the mode bit set
    post_inc    = indirect & word[AODEC_INC_BIT];                  // RQ16
    post_dec    = indirect & word[AODEC_DEC_BIT];                  // RQ16
    ptr_load    = indirect & ~word[AODEC_KEEP_BIT];                // RQ16
    ptr_value   = word[AODEC_PTR_BIT];
  end

endmodule

// file: verilog/aodec_core.sv
/*
  Decoder for the accumulator and memory-reference instruction group.
  Assumes the fetch path presents one word per cycle with word_valid,
  the page pointer and two auxiliary register values from the datapath.
*/
// Operation
// RQ1: Group instructions are one word, one cycle
// RQ2: Only branch and I/O flagged multi-cycle
// RQ3: Fixed word decodes as magnitude, no operand
// RQ4: Top nibble 0000 is shifted add
// RQ5: Upper byte 60h add_unsigned_lower_op to upper half
// RQ6: Upper byte 61h add_unsigned_lower_op unsigned low
// RQ7: Top nibble 0010 is shifted load
// RQ8: Upper byte 7Eh loads short constant
// RQ9: Upper byte 0101 1xxx stores upper half
// RQ10: Upper byte 62h subtracts from upper half
// RQ11: Extract four-bit shift code, zero to fifteen
// RQ12: Extract three-bit store shift field
// RQ13: Low byte splits into mode and address
// RQ14: Direct uses page bit, indirect auxiliary register
// RQ15: Page bit is direct address msb
// RQ16: Indirect bits increment, decrement, reload pointer
// RQ17: Select and fields combinational, one-hot select
// RQ18: Unknown words flagged, no update requested
`timescale 1ns/10ps
module aodec_core
  import aodec_pkg::*;
(
  input  wire logic              clk,               // Core clock
  input  wire logic              resetn,            // Async reset, low
  input  wire logic [15:0]       word,              // Fetched word
  input  wire logic              word_valid,        // Word present
  input  wire aodec_class_t      word_class,        // Group from predecoder
  input  wire logic              page_select_bit,   // Data page pointer
  input  wire logic              aux_reg_select,    // Current aux register
  input  wire logic [7:0]        aux_reg0,          // Auxiliary register 0
  input  wire logic [7:0]        aux_reg1,          // Auxiliary register 1
  output aodec_sel_t             op_sel,            // Operation select
  output logic      [8:0]        op_onehot,         // One-hot select
  output logic                   multi_cycle,       // Class may stall
  output logic      [1:0]        cycles,            // Cycle count
  output logic      [1:0]        words,             // Word count
  output logic                   unsupported,       // No match
  output logic                   acc_write,         // Accumulator update
  output logic                   mem_read,          // Operand fetch
  output logic                   mem_write,         // Memory store
  output logic      [3:0]        shift_code,        // Four-bit shift
  output logic      [2:0]        store_shift,       // Three-bit shift
  output logic      [7:0]        operand_addr,      // Effective address
  output logic      [7:0]        short_const,       // Immediate constant
  output logic                   sign_ext_off,      // Unsigned operand
  output logic                   upper_half,        // Targets upper half
  output logic                   is_subtract,       // Subtract form
  output logic                   aux_inc,           // Post-increment
  output logic                   aux_dec,           // Post-decrement
  output logic                   aux_ptr_load,      // Pointer reload
  output logic                   aux_ptr_value,     // Pointer new value
  output logic      [7:0]        decoded_count,     // Registered count
  output logic      [7:0]        unsupported_count  // Registered count
);

  // ----------------------------------------------------------------
  // Constants local to the decode
  // ----------------------------------------------------------------
  localparam logic [1:0] AODEC_ONE      = 2'h1;     // One word, one cycle
  localparam logic [7:0] AODEC_CNT_ZERO = 8'h00;    // Counter reset value
  localparam logic [7:0] AODEC_CNT_STEP = 8'h01;    // Counter increment

  // ----------------------------------------------------------------
  // Field extraction
  // ----------------------------------------------------------------
  logic [3:0] f_shift4;       // Shift code field
  logic [2:0] f_shift3;       // Store shift field
  logic       f_indirect;     // Mode bit
  logic [6:0] f_dma;          // Direct address field
  logic [7:0] f_direct;       // Page-joined address
  logic [7:0] f_const;        // Low byte constant
  logic       f_inc;          // Increment control
  logic       f_dec;          // Decrement control
  logic       f_ptr_load;     // Pointer reload control
  logic       f_ptr_value;    // Pointer reload value

  aodec_fields u_fields (
    .word            (word),
    .page_select_bit (page_select_bit),
    .shift4          (f_shift4),
    .shift3          (f_shift3),
    .indirect        (f_indirect),
    .dma             (f_dma),
    .direct_addr     (f_direct),
    .short_const     (f_const),
    .post_inc        (f_inc),
    .post_dec        (f_dec),
    .ptr_load        (f_ptr_load),
    .ptr_value       (f_ptr_value)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Does this select read or write a data memory operand
  function automatic logic uses_memory(input aodec_sel_t s);
    case (s)
      AODEC_SEL_ADD_SHIFTED, AODEC_SEL_ADD_UPPER, AODEC_SEL_ADD_UNSIGNED,
      AODEC_SEL_LOAD_SHIFTED, AODEC_SEL_STORE_UPPER,
      AODEC_SEL_SUB_UPPER: uses_memory = 1'b1;
      default:             uses_memory = 1'b0;
    endcase
  endfunction

  // One-hot vector of a select, bit index is enum position
  function automatic logic [8:0] onehot_of(input aodec_sel_t s);
    onehot_of = 9'h001 << s;
  endfunction

  // ----------------------------------------------------------------
  // Opcode match
  // ----------------------------------------------------------------
  aodec_sel_t next_sel;       // Decoded select
  logic [7:0] upper;          // Upper byte
  logic [3:0] top;            // Top nibble

  always_comb begin
    upper    = word[AODEC_BYTE_HI:AODEC_BYTE_LO];
    top      = word[AODEC_NIB_HI:AODEC_NIB_LO];
    next_sel = AODEC_SEL_NONE;
    // Only words of this group are decoded at all
    if (word_valid && word_class == AODEC_CLASS_ACC_MEM) begin
      // Exact word checked first; its upper byte matches no other row
      if (word == AODEC_WORD_MAG) begin
        next_sel = AODEC_SEL_MAGNITUDE;                              // RQ3
      end else if (top == AODEC_NIB_ADD) begin
        next_sel = AODEC_SEL_ADD_SHIFTED;                            // RQ4
      end else if (top == AODEC_NIB_LOAD) begin
        next_sel = AODEC_SEL_LOAD_SHIFTED;                           // RQ7
      end else if (top == AODEC_NIB_STH && word[AODEC_SH3_TOP]) begin
        next_sel = AODEC_SEL_STORE_UPPER;                            // RQ9
      end else begin
        case (upper)
          AODEC_OP_ADD_UPPER_HALF_OP: next_sel = AODEC_SEL_ADD_UPPER;             // RQ5
          AODEC_OP_ADD_UNSIGNED_LOWER_OP: next_sel = AODEC_SEL_ADD_UNSIGNED;          // RQ6
          AODEC_OP_SUB_UPPER_HALF_OP: next_sel = AODEC_SEL_SUB_UPPER;             // RQ10
          AODEC_OP_LDK:  next_sel = AODEC_SEL_LOAD_CONST;            // RQ8
          default:       next_sel = AODEC_SEL_NONE;                  // RQ18
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Decoded outputs, same cycle as the word
  // ----------------------------------------------------------------
  always_comb begin
    op_sel        = next_sel;                                        // RQ17
    op_onehot     = (next_sel == AODEC_SEL_NONE) ? 9'h000 : onehot_of(next_sel); // RQ17
    // Branch and I/O are the only multi-cycle classes
    multi_cycle   = word_valid && (word_class == AODEC_CLASS_BRANCH ||
                                   word_class == AODEC_CLASS_IO);    // RQ2
    cycles        = AODEC_ONE;                                       // RQ1
    words         = AODEC_ONE;                                       // RQ1
    unsupported   = word_valid && (word_class == AODEC_CLASS_ACC_MEM) &&
                    (next_sel == AODEC_SEL_NONE);                    // RQ18
    // Unmatched words request nothing
    acc_write     = (next_sel != AODEC_SEL_NONE) &&
                    (next_sel != AODEC_SEL_STORE_UPPER);             // RQ18
    mem_read      = uses_memory(next_sel) && (next_sel != AODEC_SEL_STORE_UPPER);
    mem_write     = (next_sel == AODEC_SEL_STORE_UPPER);
    shift_code    = f_shift4;                                        // RQ11
    store_shift   = f_shift3;                                        // RQ12
    short_const   = f_const;                                         // RQ8
    sign_ext_off  = (next_sel == AODEC_SEL_ADD_UNSIGNED);            // RQ6
    upper_half    = (next_sel == AODEC_SEL_ADD_UPPER) ||
                    (next_sel == AODEC_SEL_SUB_UPPER) ||
                    (next_sel == AODEC_SEL_STORE_UPPER);
    is_subtract   = (next_sel == AODEC_SEL_SUB_UPPER);               // RQ10
    // Address: page-joined field or the selected auxiliary register
    if (f_indirect) begin
      operand_addr = aux_reg_select ? aux_reg1 : aux_reg0;           // RQ14
    end else begin
      operand_addr = f_direct;                                       // RQ14
    end
    // Aux updates only for operand words; magnitude has none
    aux_inc       = uses_memory(next_sel) && f_inc;                  // RQ16
    aux_dec       = uses_memory(next_sel) && f_dec;                  // RQ16
    aux_ptr_load  = uses_memory(next_sel) && f_ptr_load;             // RQ16
    aux_ptr_value = f_ptr_value;
  end

  // ----------------------------------------------------------------
  // Activity counters, wrap silently; aid for bring-up only
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      decoded_count <= AODEC_CNT_ZERO;
    end else if (next_sel != AODEC_SEL_NONE) begin
      decoded_count <= decoded_count + AODEC_CNT_STEP;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      unsupported_count <= AODEC_CNT_ZERO;
    end else if (unsupported) begin
      unsupported_count <= unsupported_count + AODEC_CNT_STEP;       // RQ18
    end
  end

endmodule

// file: verif/aodec_core_chk.sv
/*
  Assertion checker for aodec_core, bound to its top-level ports.
  Assumes one clock domain and the active-low asynchronous reset.
*/
`timescale 1ns/10ps
module aodec_core_chk
  import aodec_pkg::*;
(
  input wire logic         clk,
  input wire logic         resetn,
  input wire logic [15:0]  word,
  input wire logic         word_valid,
  input wire aodec_class_t word_class,
  input wire logic         page_select_bit,
  input wire aodec_sel_t   op_sel,
  input wire logic [8:0]   op_onehot,
  input wire logic         multi_cycle,
  input wire logic [1:0]   cycles,
  input wire logic         unsupported,
  input wire logic         acc_write,
  input wire logic         mem_write,
  input wire logic [3:0]   shift_code,
  input wire logic [7:0]   operand_addr,
  input wire logic [7:0]   decoded_count
);
  // ----
  // Decode relations
  // ----
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // Word offered to this group
  sequence grp_word;
    word_valid && word_class == AODEC_CLASS_ACC_MEM;
  endsequence
  // Some operation chosen
  sequence picked;
    op_sel != AODEC_SEL_NONE;
  endsequence
  magnitude_word_a: assert property (grp_word ##0 (word == AODEC_WORD_MAG) |-> op_sel == AODEC_SEL_MAGNITUDE)
    else $error("fixed word not decoded as magnitude");
  add_shift_a: assert property (grp_word ##0 (word[15:12] == AODEC_NIB_ADD) |->
    op_sel == AODEC_SEL_ADD_SHIFTED && shift_code == word[11:8])
    else $error("shifted add decode wrong");
  direct_addr_a: assert property (picked ##0 (!word[7] && op_sel != AODEC_SEL_LOAD_CONST) |->
    operand_addr == {page_select_bit, word[6:0]})
    else $error("direct address not page joined");
  onehot_sel_a: assert property (op_onehot == ((op_sel == AODEC_SEL_NONE) ? 9'h000 : 9'h001 << op_sel))
    else $error("one-hot select disagrees");
  multi_flag_a: assert property (multi_cycle == (word_valid && word_class inside {AODEC_CLASS_BRANCH, AODEC_CLASS_IO}))
    else $error("multi-cycle flag wrong");
  one_cycle_a: assert property (cycles == 2'h1)
    else $error("cycle count not one");
  unknown_quiet_a: assert property (unsupported |-> op_sel == AODEC_SEL_NONE && !acc_write && !mem_write)
    else $error("unsupported word requests update");
  refused_word_a: assert property (!word_valid |-> op_sel == AODEC_SEL_NONE && !unsupported)
    else $error("absent word decoded");
  store_form_a: assert property (op_sel == AODEC_SEL_STORE_UPPER |-> mem_write && !acc_write)
    else $error("store upper half controls wrong");
  count_step_a: assert property (picked |=> decoded_count == $past(decoded_count) + 8'h01)
    else $error("decoded count did not step");
endmodule

bind aodec_core aodec_core_chk chk_u (
  .clk, .resetn, .word, .word_valid, .word_class, .page_select_bit, .op_sel, .op_onehot,
  .multi_cycle, .cycles, .unsupported, .acc_write, .mem_write, .shift_code, .operand_addr, .decoded_count
);

// file: verif/aodec_fetch_model.sv
/*
  Datapath partner: the two auxiliary registers and their pointer.
  Assumes the decoder only requests updates for memory forms.
*/
`timescale 1ns/10ps
module aodec_fetch_model #(
  parameter logic [7:0] AUX0_INIT = 8'h33,  // Arbitrary start value
  parameter logic [7:0] AUX1_INIT = 8'hc4   // Arbitrary start value
) (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       word_valid,
  input  wire logic       aux_inc,
  input  wire logic       aux_dec,
  input  wire logic       aux_ptr_load,
  input  wire logic       aux_ptr_value,
  output logic            aux_reg_select,
  output logic [7:0]      aux_reg0,
  output logic [7:0]      aux_reg1
);
  // ----
  // Post-access updates
  // ----
  // Step only after the access, so the old value addresses memory
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      aux_reg0 <= AUX0_INIT;
      aux_reg1 <= AUX1_INIT;
    end else if (word_valid && !aux_reg_select) begin
      aux_reg0 <= aux_reg0 + {7'h00, aux_inc} - {7'h00, aux_dec};
    end else if (word_valid) begin
      aux_reg1 <= aux_reg1 + {7'h00, aux_inc} - {7'h00, aux_dec};
    end
  end
  // Pointer has no defined reset value; zero keeps the bench simple
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      aux_reg_select <= 1'b0;
    end else if (word_valid && aux_ptr_load) begin
      aux_reg_select <= aux_ptr_value;
    end
  end
endmodule

// file: verif/tb.sv
/*
  Self-checking bench for aodec_core: a table of words, then class,
  indirect, store-shift and reset cases. Partner holds aux registers.
*/
`timescale 1ns/10ps
module tb
  import aodec_pkg::*;
;
  typedef struct packed {
    logic [15:0] w;
    logic        pg;
    aodec_sel_t  sel;
    logic [3:0]  sh;
    logic [7:0]  v8;
  } aodec_row_t;
  logic clk, resetn, word_valid, page_select_bit, aux_reg_select, multi_cycle, unsupported, mem_read;
  logic acc_write, mem_write, sign_ext_off, upper_half, is_subtract, aux_inc, aux_dec, aux_ptr_load, aux_ptr_value;
  logic [15:0] word;
  aodec_class_t word_class;
  aodec_sel_t op_sel;
  logic [1:0] cycles, words;
  logic [3:0] shift_code;
  logic [2:0] store_shift;
  logic [7:0] aux_reg0, aux_reg1, operand_addr, short_const, decoded_count, unsupported_count;
  logic [7:0] n_dec = 8'h00;
  logic [7:0] n_uns = 8'h00;
  int mismatches = 0;
  int num_checks = 0;
  aodec_row_t r;
  logic [15:0] ind_w [4] = '{16'h08a1, 16'h0898, 16'h0880, 16'h0888};
  logic [7:0] ind_a [4] = '{8'h33, 8'hc4, 8'hc3, 8'h34};
  aodec_row_t rows [13] = '{
    '{16'h7f88, 1'b0, AODEC_SEL_MAGNITUDE, 4'hf, 8'h00}, '{16'h0509, 1'b0, AODEC_SEL_ADD_SHIFTED, 4'h5, 8'h09},
    '{16'h0f7f, 1'b1, AODEC_SEL_ADD_SHIFTED, 4'hf, 8'hff}, '{16'h6012, 1'b1, AODEC_SEL_ADD_UPPER, 4'h0, 8'h92},
    '{16'h6188, 1'b0, AODEC_SEL_ADD_UNSIGNED, 4'h1, 8'h33}, '{16'h2a40, 1'b0, AODEC_SEL_LOAD_SHIFTED, 4'ha, 8'h40},
    '{16'h2000, 1'b1, AODEC_SEL_LOAD_SHIFTED, 4'h0, 8'h80}, '{16'h7edd, 1'b0, AODEC_SEL_LOAD_CONST, 4'he, 8'hdd},
    '{16'h5f05, 1'b0, AODEC_SEL_STORE_UPPER, 4'hf, 8'h05}, '{16'h6208, 1'b1, AODEC_SEL_SUB_UPPER, 4'h2, 8'h88},
    '{16'h5705, 1'b0, AODEC_SEL_NONE, 4'h7, 8'h00}, '{16'h7f89, 1'b0, AODEC_SEL_NONE, 4'hf, 8'h00},
    '{16'h7000, 1'b0, AODEC_SEL_NONE, 4'h0, 8'h00}};

  aodec_core dut_u (.clk, .resetn, .word, .word_valid, .word_class, .page_select_bit, .aux_reg_select,
    .aux_reg0, .aux_reg1, .op_sel, .op_onehot(), .multi_cycle, .cycles, .words, .unsupported, .acc_write,
    .mem_read, .mem_write, .shift_code, .store_shift, .operand_addr, .short_const, .sign_ext_off, .upper_half,
    .is_subtract, .aux_inc, .aux_dec, .aux_ptr_load, .aux_ptr_value, .decoded_count, .unsupported_count);
  aodec_fetch_model model_u (.clk, .resetn, .word_valid, .aux_inc, .aux_dec, .aux_ptr_load, .aux_ptr_value,
    .aux_reg_select, .aux_reg0, .aux_reg1);

  // ----
  // Drivers and comparisons
  // ----
  task automatic tally(input logic ok, input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    tally(got === exp, {8'h00, got}, {8'h00, exp});
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    tally(got === exp, {15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic chk_sel(input aodec_sel_t got, input aodec_sel_t exp);
    tally(got === exp, {12'h000, got}, {12'h000, exp});
  endtask
  // Drive just after the edge, then let the decode settle
  task automatic put(input logic [15:0] w, input logic v, input aodec_class_t c, input logic pg);
    @(posedge clk);
    #1;
    word = w;
    word_valid = v;
    word_class = c;
    page_select_bit = pg;
    #1;
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    resetn = 1'b0;
    word = 16'h0000;
    word_valid = 1'b0;
    word_class = AODEC_CLASS_ACC_MEM;
    page_select_bit = 1'b0;
    repeat (10) @(posedge clk);
    #1;
    chk_val(decoded_count, 8'h00);
    resetn = 1'b1;
    foreach (rows[i]) begin
      r = rows[i];
      put(r.w, 1'b1, AODEC_CLASS_ACC_MEM, r.pg);
      chk_sel(op_sel, r.sel);
      chk_val({4'h0, shift_code}, {4'h0, r.sh});
      chk_bit(unsupported, r.sel == AODEC_SEL_NONE);
      chk_bit(mem_write, r.sel == AODEC_SEL_STORE_UPPER);
      // Operand fetch only for forms that read data memory
      chk_bit(mem_read, r.sel inside {AODEC_SEL_ADD_SHIFTED, AODEC_SEL_ADD_UPPER, AODEC_SEL_ADD_UNSIGNED,
                                      AODEC_SEL_LOAD_SHIFTED, AODEC_SEL_SUB_UPPER});
      chk_bit(acc_write, !(r.sel inside {AODEC_SEL_NONE, AODEC_SEL_STORE_UPPER}));
      chk_bit(upper_half, r.sel inside {AODEC_SEL_ADD_UPPER, AODEC_SEL_SUB_UPPER, AODEC_SEL_STORE_UPPER});
      chk_bit(sign_ext_off, r.sel == AODEC_SEL_ADD_UNSIGNED);
      chk_bit(is_subtract, r.sel == AODEC_SEL_SUB_UPPER);
      if (r.sel == AODEC_SEL_LOAD_CONST) begin
        chk_val(short_const, r.v8);
      end else if (!(r.sel inside {AODEC_SEL_NONE, AODEC_SEL_MAGNITUDE})) begin
        chk_val(operand_addr, r.v8);
      end
      if (r.sel == AODEC_SEL_NONE) n_uns = n_uns + 8'h01;
      else n_dec = n_dec + 8'h01;
    end
    put(16'h0000, 1'b0, AODEC_CLASS_ACC_MEM, 1'b0);
    chk_val(decoded_count, n_dec);
    chk_val(unsupported_count, n_uns);
    $display("table test done");
    for (int c = 0; c < 4; c++) begin
      put(16'h0589, 1'b1, aodec_class_t'(c), 1'b0);
      chk_bit(multi_cycle, c == 1 || c == 2);
      chk_bit(unsupported, 1'b0);
      chk_sel(op_sel, (c == 0) ? AODEC_SEL_ADD_SHIFTED : AODEC_SEL_NONE);
      chk_val({6'h00, cycles}, 8'h01);
      chk_val({6'h00, words}, 8'h01);
    end
    put(16'h0589, 1'b0, AODEC_CLASS_BRANCH, 1'b0);
    chk_bit(multi_cycle, 1'b0);
    chk_bit(unsupported, 1'b0);
    $display("class test done");
    for (int i = 0; i < 4; i++) begin
      put(ind_w[i], 1'b1, AODEC_CLASS_ACC_MEM, 1'b1);
      chk_val(operand_addr, ind_a[i]);
      chk_bit(aux_inc, ind_w[i][5]);
      chk_bit(aux_dec, ind_w[i][4]);
      chk_bit(aux_ptr_load, !ind_w[i][3]);
      chk_bit(aux_ptr_value, ind_w[i][0]);
    end
    $display("indirect test done");
    put(16'h5d00, 1'b1, AODEC_CLASS_ACC_MEM, 1'b0);
    chk_val({5'h00, store_shift}, 8'h05);
    // Mid-run reset, driven at the usual offset after the edge
    @(posedge clk);
    #1;
    resetn = 1'b0;
    #1;
    chk_val(decoded_count, 8'h00);
    chk_val(unsupported_count, 8'h00);
    // Release with the store word still held: first edge must count it
    @(posedge clk);
    #1;
    resetn = 1'b1;
    put(16'h0000, 1'b0, AODEC_CLASS_ACC_MEM, 1'b0);
    chk_val(decoded_count, 8'h01);
    chk_val(unsupported_count, 8'h00);
    $display("store and reset test done");
    test_done();
  end
endmodule
